// ### src/bscc_pkg.sv
// What this block does
// - poisoned tlp sets detected parity error
// - error message with serr enable sets flag
// - unsupported-request completion sets master abort flag
// - completer-abort completion sets target abort flag
// - completing with completer abort sets signaled flag
// - gated poisoned data sets master parity flag
// - event flags sticky until software clears
// - speed, fast b2b, high_speed_capable, reserved read zero
// - capabilities present bit always reads one
// - interrupt status bit always reads zero
// - class fields fixed bridge, pci bridge, zero
// - fixed read-only silicon revision in low byte
// - cache line size steers delayed read prefetch
// - odd or over 32 dwords means zero
// - parity response enable gates master parity flag
// - system error report enable gates error reporting
package bscc_pkg;

	// ****************************************************************
	// configuration map, byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_COMMAND = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h06;
	localparam logic [7:0] OFF_CLASS = 8'h08;
	localparam logic [7:0] OFF_CACHE_LINE = 8'h0C;
	localparam int DW_LSB = 2;
	localparam int HALF_W = 16;

	// ****************************************************************
	// command and status fields
	// ****************************************************************
	localparam int CMD_PERR_BIT = 6;
	localparam int CMD_SERR_BIT = 8;
	localparam int ST_DETECTED_PARITY = 15;
	localparam int ST_SIGNALED_SYSERR = 14;
	localparam int ST_RECEIVED_RECEIVED_MASTER_ABORT = 13;
	localparam int ST_RECEIVED_TABORT = 12;
	localparam int ST_SIGNALED_TABORT = 11;
	localparam int ST_SPEED_HI = 10;
	localparam int ST_SPEED_LO = 9;
	localparam int ST_MASTER_PARITY = 8;
	localparam int ST_FAST_B2B = 7;
	localparam int ST_HIGH_SPEED = 5;
	localparam int ST_CAP_PRESENT = 4;
	localparam int ST_INT_STATUS = 3;
	localparam logic [15:0] STATUS_RESET = 16'h0010;
	localparam logic [15:0] STATUS_FIXED = 16'h0010;

	// flag vector indices inside the sticky bank
	localparam int FLAG_N = 6;
	localparam int FL_MASTER_PARITY = 0;
	localparam int FL_SIGNALED_TABORT = 1;
	localparam int FL_RECEIVED_TABORT = 2;
	localparam int FL_RECEIVED_RECEIVED_MASTER_ABORT = 3;
	localparam int FL_SIGNALED_SYSERR = 4;
	localparam int FL_DETECTED_PARITY = 5;

	// ****************************************************************
	// class code and cache line
	// ****************************************************************
	localparam logic [7:0] BASE_CLASS = 8'h06;
	localparam logic [7:0] SUB_CLASS = 8'h04;
	localparam logic [7:0] PROG_IF = 8'h00;
	localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
	localparam logic [7:0] CACHE_LINE_MAX = 8'h20;

	// maps the sticky flags onto their status positions
	function automatic logic [15:0] status_word(input logic [FLAG_N-1:0] f);
		logic [15:0] w;
		w = STATUS_FIXED;
		w[ST_MASTER_PARITY] = f[FL_MASTER_PARITY];
		w[ST_SIGNALED_TABORT] = f[FL_SIGNALED_TABORT];
		w[ST_RECEIVED_TABORT] = f[FL_RECEIVED_TABORT];
		w[ST_RECEIVED_RECEIVED_MASTER_ABORT] = f[FL_RECEIVED_RECEIVED_MASTER_ABORT];
		w[ST_SIGNALED_SYSERR] = f[FL_SIGNALED_SYSERR];
		w[ST_DETECTED_PARITY] = f[FL_DETECTED_PARITY];
		return w;
	endfunction : status_word

	// picks the flag bits out of a written status half-word
	function automatic logic [FLAG_N-1:0] status_flags(input logic [15:0] w);
		logic [FLAG_N-1:0] f;
		f = '0;
		f[FL_MASTER_PARITY] = w[ST_MASTER_PARITY];
		f[FL_SIGNALED_TABORT] = w[ST_SIGNALED_TABORT];
		f[FL_RECEIVED_TABORT] = w[ST_RECEIVED_TABORT];
		f[FL_RECEIVED_RECEIVED_MASTER_ABORT] = w[ST_RECEIVED_RECEIVED_MASTER_ABORT];
		f[FL_SIGNALED_SYSERR] = w[ST_SIGNALED_SYSERR];
		f[FL_DETECTED_PARITY] = w[ST_DETECTED_PARITY];
		return f;
	endfunction : status_flags

	// odd or oversize line sizes collapse to zero dwords
	function automatic logic [7:0] line_eff(input logic [7:0] v);
		return (v[0] || (v > CACHE_LINE_MAX)) ? 8'h00 : v;
	endfunction : line_eff

	// dword match on a byte address
	function automatic logic dw_hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:DW_LSB] == off[7:DW_LSB];
	endfunction : dw_hit

endpackage : bscc_pkg

// ### src/bscc_regs.sv
`timescale 1ns/1ns
module bscc_regs
#(
	parameter logic [7:0] SILICON_REV = 8'h01 // value is arbitrary
)
(
	input wire logic clk, // core clock, 100 MHz
	input wire logic rst_b, // synchronous reset, active low
	input wire logic cfg_req, // configuration request strobe
	input wire logic cfg_we, // 1 write, 0 read
	input wire logic [7:0] cfg_addr, // byte address, dword granular
	input wire logic [3:0] cfg_be, // byte enables
	input wire logic [31:0] cfg_wdata, // write data
	output logic [31:0] cfg_rdata, // read data, valid with ack
	output logic cfg_ack, // one-cycle completion pulse
	input wire logic ev_poisoned_tlp, // poisoned tlp received
	input wire logic ev_err_msg_sent, // fatal or nonfatal message sent
	input wire logic ev_cpl_unsupported, // completion with ur received
	input wire logic ev_cpl_abort, // completion with ca received
	input wire logic ev_abort_signaled, // request completed with ca
	input wire logic ev_poisoned_cpl_data, // poisoned completion with data
	input wire logic ev_poisoned_write, // received write was poisoned
	output logic parity_response_enable, // command bit, registered
	output logic system_error_report_enable, // command bit, registered
	output logic [7:0] prefetch_dwords // effective delayed read prefetch
);

	// ****************************************************************
	// request decode
	// ****************************************************************
	logic hit_cmd;
	logic hit_class;
	logic hit_cache;
	logic wr;
	logic rd;

	// status shares the dword with command, bytes two and three
	always_comb
	begin
		hit_cmd = bscc_pkg::dw_hit(cfg_addr, bscc_pkg::OFF_COMMAND);
		hit_class = bscc_pkg::dw_hit(cfg_addr, bscc_pkg::OFF_CLASS);
		hit_cache = bscc_pkg::dw_hit(cfg_addr, bscc_pkg::OFF_CACHE_LINE);
		wr = cfg_req && cfg_we;
		rd = cfg_req && !cfg_we;
	end

	// ****************************************************************
	// command enables and cache line size
	// ****************************************************************
	logic perr_en_r;
	logic perr_en_nxt;
	logic serr_en_r;
	logic serr_en_nxt;
	logic [7:0] line_r;
	logic [7:0] line_nxt;
	logic [7:0] pf_r;
	logic [7:0] pf_nxt;

	// the raw line size is kept for readback; only the prefetch engine
	// sees the collapsed value, so software can still see what it wrote
	always_comb
	begin
		perr_en_nxt = perr_en_r;
		serr_en_nxt = serr_en_r;
		line_nxt = line_r;
		if (wr && hit_cmd && cfg_be[0])
			perr_en_nxt = cfg_wdata[bscc_pkg::CMD_PERR_BIT];
		if (wr && hit_cmd && cfg_be[1])
			serr_en_nxt = cfg_wdata[bscc_pkg::CMD_SERR_BIT];
		if (wr && hit_cache && cfg_be[0])
			line_nxt = cfg_wdata[7:0];
		pf_nxt = bscc_pkg::line_eff(line_nxt);
	end

	// register stage
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			perr_en_r <= 1'b0;
			serr_en_r <= 1'b0;
			line_r <= bscc_pkg::CACHE_LINE_RESET;
			pf_r <= bscc_pkg::CACHE_LINE_RESET;
		end
		else
		begin
			perr_en_r <= perr_en_nxt;
			serr_en_r <= serr_en_nxt;
			line_r <= line_nxt;
			pf_r <= pf_nxt;
		end
	end

	// ****************************************************************
	// status event flags
	// ****************************************************************
	logic [bscc_pkg::FLAG_N-1:0] set_vec;
	logic [bscc_pkg::FLAG_N-1:0] clr_vec;
	logic [bscc_pkg::FLAG_N-1:0] flags;

	// event qualification; clears are write-one on byte three
	always_comb
	begin
		set_vec = '0;
		set_vec[bscc_pkg::FL_DETECTED_PARITY] = ev_poisoned_tlp;
		set_vec[bscc_pkg::FL_SIGNALED_SYSERR] = ev_err_msg_sent && serr_en_r;
		set_vec[bscc_pkg::FL_RECEIVED_RECEIVED_MASTER_ABORT] = ev_cpl_unsupported;
		set_vec[bscc_pkg::FL_RECEIVED_TABORT] = ev_cpl_abort;
		set_vec[bscc_pkg::FL_SIGNALED_TABORT] = ev_abort_signaled;
		set_vec[bscc_pkg::FL_MASTER_PARITY] =
			perr_en_r && (ev_poisoned_cpl_data || ev_poisoned_write);
		clr_vec = '0;
		if (wr && hit_cmd && cfg_be[3])
			clr_vec = bscc_pkg::status_flags({cfg_wdata[31:24], 8'h00});
	end

	bscc_sticky_flags u_flags
	(
		.clk(clk),
		.rst_b(rst_b),
		.set_vec(set_vec),
		.clr_vec(clr_vec),
		.flags(flags)
	);

	// ****************************************************************
	// read path
	// ****************************************************************
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [15:0] cmd_word;

	// unmapped dwords and writes answer with zero data
	always_comb
	begin
		cmd_word = '0;
		cmd_word[bscc_pkg::CMD_PERR_BIT] = perr_en_r;
		cmd_word[bscc_pkg::CMD_SERR_BIT] = serr_en_r;
		ack_nxt = cfg_req;
		rdata_nxt = '0;
		if (rd && hit_cmd)
			rdata_nxt = {bscc_pkg::status_word(flags), cmd_word};
		else if (rd && hit_class)
			rdata_nxt = {bscc_pkg::BASE_CLASS, bscc_pkg::SUB_CLASS,
				bscc_pkg::PROG_IF, SILICON_REV};
		else if (rd && hit_cache)
			rdata_nxt = {24'h000000, line_r};
	end

	// register stage
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rdata_r <= '0;
			ack_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
		end
	end

	assign cfg_rdata = rdata_r;
	assign cfg_ack = ack_r;
	assign parity_response_enable = perr_en_r;
	assign system_error_report_enable = serr_en_r;
	assign prefetch_dwords = pf_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_parity_sets: assert property (
		ev_poisoned_tlp |=> flags[bscc_pkg::FL_DETECTED_PARITY])
		else $error("detected parity flag did not set");

	a_syserr_gated: assert property (
		(ev_err_msg_sent && serr_en_r) |=> flags[bscc_pkg::FL_SIGNALED_SYSERR])
		else $error("signaled system error flag did not set");

	a_syserr_off: assert property (
		(!serr_en_r && !flags[bscc_pkg::FL_SIGNALED_SYSERR])
		|=> !flags[bscc_pkg::FL_SIGNALED_SYSERR])
		else $error("system error flag set while reporting disabled");

	a_received_master_abort_sets: assert property (
		ev_cpl_unsupported |=> flags[bscc_pkg::FL_RECEIVED_RECEIVED_MASTER_ABORT])
		else $error("received master abort flag did not set");

	a_rtabort_sets: assert property (
		ev_cpl_abort |=> flags[bscc_pkg::FL_RECEIVED_TABORT])
		else $error("received target abort flag did not set");

	a_stabort_sets: assert property (
		ev_abort_signaled |=> flags[bscc_pkg::FL_SIGNALED_TABORT])
		else $error("signaled target abort flag did not set");

	a_mparity_sets: assert property (
		(perr_en_r && ev_poisoned_write) |=> flags[bscc_pkg::FL_MASTER_PARITY])
		else $error("master data parity flag did not set");

	a_mparity_cpl: assert property (
		(perr_en_r && ev_poisoned_cpl_data) |=> flags[bscc_pkg::FL_MASTER_PARITY])
		else $error("master data parity flag missed a poisoned completion");

	a_mparity_gated: assert property (
		(!perr_en_r && !flags[bscc_pkg::FL_MASTER_PARITY])
		|=> !flags[bscc_pkg::FL_MASTER_PARITY])
		else $error("master parity flag set with parity response off");

	a_flags_sticky: assert property (
		(clr_vec == '0) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("status flag dropped without a clear");

	a_set_wins: assert property (
		((set_vec & clr_vec) != '0) |=>
		((flags & $past(set_vec & clr_vec)) == $past(set_vec & clr_vec)))
		else $error("event lost against a clear");

	a_status_fixed: assert property (
		(rd && hit_cmd) |=> (cfg_ack &&
		cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_CAP_PRESENT] &&
		!cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_INT_STATUS] &&
		!cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_SPEED_HI] &&
		!cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_SPEED_LO] &&
		!cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_FAST_B2B] &&
		!cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_HIGH_SPEED]))
		else $error("status fixed bits wrong");

	a_status_zero: assert property (
		(rd && hit_cmd) |=> ((cfg_rdata[31:16] & ~bscc_pkg::status_word('1)) == 16'h0000))
		else $error("status reserved or speed bits not zero");

	a_int_status: assert property (
		(rd && hit_cmd) |=> !cfg_rdata[bscc_pkg::HALF_W + bscc_pkg::ST_INT_STATUS])
		else $error("interrupt status bit read as one");

	a_class_read: assert property (
		(rd && hit_class) |=> (cfg_ack && cfg_rdata ==
		{bscc_pkg::BASE_CLASS, bscc_pkg::SUB_CLASS, bscc_pkg::PROG_IF, SILICON_REV}))
		else $error("class register readback wrong");

	a_rev_read: assert property (
		(rd && hit_class) |=> (cfg_rdata[7:0] == SILICON_REV))
		else $error("silicon revision byte wrong");

	a_line_eff: assert property (
		(wr && hit_cache && cfg_be[0]) |=>
		(prefetch_dwords == bscc_pkg::line_eff($past(cfg_wdata[7:0]))))
		else $error("prefetch size not derived from written line size");

	a_prefetch_legal: assert property (
		!prefetch_dwords[0] && (prefetch_dwords <= bscc_pkg::CACHE_LINE_MAX))
		else $error("prefetch size odd or oversize");

	a_prefetch_hold: assert property (
		!(wr && hit_cache && cfg_be[0]) |=> $stable(prefetch_dwords))
		else $error("prefetch size moved without a line size write");

	// every request is answered in the next cycle
	a_ack_follows: assert property ( // answer timing
		cfg_req |=> cfg_ack)
		else $error("request not acknowledged one cycle later");

	c_collision: cover property ((set_vec & clr_vec) != '0);
	c_status_read: cover property ((rd && hit_cmd) ##1 (cfg_rdata[31:16] != bscc_pkg::STATUS_FIXED));
	c_line_valid: cover property (wr && hit_cache && cfg_be[0] ##1 prefetch_dwords != 8'h00);
	c_line_odd: cover property (wr && hit_cache && cfg_be[0] && cfg_wdata[0]);

endmodule : bscc_regs

// ### src/bscc_sticky_flags.sv
`timescale 1ns/1ns
module bscc_sticky_flags
(
	input wire logic clk, // core clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic [bscc_pkg::FLAG_N-1:0] set_vec, // hardware events
	input wire logic [bscc_pkg::FLAG_N-1:0] clr_vec, // software clears
	output logic [bscc_pkg::FLAG_N-1:0] flags // sticky flags
);

	logic [bscc_pkg::FLAG_N-1:0] flags_r;
	logic [bscc_pkg::FLAG_N-1:0] flags_nxt;

	// set is or-ed in after the clear so a colliding event survives
	always_comb
	begin
		flags_nxt = (flags_r & ~clr_vec) | set_vec;
	end

	// register stage
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	assign flags = flags_r;

endmodule : bscc_sticky_flags

// ### verif/bscc_host.sv
`timescale 1ns/1ns
// ****************************************************************
// upstream configuration requester model
// ****************************************************************
module bscc_host
(
	input wire logic clk, // core clock
	output logic cfg_req, // request strobe
	output logic cfg_we, // write select
	output logic [7:0] cfg_addr, // byte address
	output logic [3:0] cfg_be, // byte enables
	output logic [31:0] cfg_wdata // write data
);
	// idle bus at time zero
	initial
	begin
		cfg_req = 1'b0;
		cfg_we = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// one strobe cycle per request; qualifiers turn to junk afterwards so
	// a design that samples them late sees wrong values, not stale ones
	task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk);
		cfg_req = 1'b1;
		cfg_we = we;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge clk);
		cfg_req = 1'b0;
		cfg_we = ~we;
		cfg_addr = ~a;
		cfg_be = ~be;
		cfg_wdata = ~d;
	endtask : xfer
endmodule : bscc_host

// ### verif/bscc_regs_test.sv
`timescale 1ns/1ns
module bscc_regs_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cfg_req, cfg_we, cfg_ack, perr_en, serr_en;
	logic [7:0] cfg_addr, pf, v;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, seed = 32'd38;
	logic [6:0] evs = 7'h0;
	logic [31:0] expq[$];
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	// ****************************************************************
	// clock, partner and design
	// ****************************************************************
	always #5 clk = ~clk;

	bscc_host host (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

	bscc_regs #(.SILICON_REV(8'h01)) DUT (.clk(clk), .rst_b(rst_b), .cfg_req(cfg_req),
		.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .ev_poisoned_tlp(evs[0]),
		.ev_err_msg_sent(evs[1]), .ev_cpl_unsupported(evs[2]), .ev_cpl_abort(evs[3]),
		.ev_abort_signaled(evs[4]), .ev_poisoned_cpl_data(evs[5]),
		.ev_poisoned_write(evs[6]), .parity_response_enable(perr_en),
		.system_error_report_enable(serr_en), .prefetch_dwords(pf));

	// ****************************************************************
	// checking helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %0t expected %h got %h", $time, e, g);
		end
	endtask : chk

	// level outputs are compared where they stand between requests
	task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %0t output expected %h got %h", $time, e, g);
		end
	endtask : chk_pin

	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// every request is answered once, writes with zero data
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		host.xfer(1'b0, a, 4'hF, xs());
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		expq.push_back(32'h0);
		host.xfer(1'b1, a, be, d);
	endtask : wr

	// event lines are high for exactly one cycle
	task automatic ev(input logic [6:0] m);
		@(negedge clk);
		evs = m;
		@(negedge clk);
		evs = 7'h0;
	endtask : ev

	// answers are looked at in their single ack cycle
	always @(negedge clk)
	begin
		if (cfg_ack === 1'b1)
		begin
			if (expq.size() == 0)
				chk(32'hFFFFFFFF, cfg_rdata);
			else
				chk(expq.pop_front(), cfg_rdata);
		end
	end

	// hang guard, the sequence needs about a hundred and ten cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			complete_run();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		logic [6:0] evt[3];
		logic [31:0] stx[3];
		logic [7:0] sizes[6];
		evt = '{7'h02, 7'h20, 7'h40};
		stx = '{32'h40100140, 32'h01100140, 32'h01100140};
		// powers of two mixed with illegal sizes
		sizes = '{8'h10, 8'h20, 8'h22, 8'h03, 8'h40, 8'h02};
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		rd(8'h04, 32'h00100000);
		rd(8'h08, 32'h06040001);
		wr(8'h08, 4'hF, 32'hFFFFFFFF);
		rd(8'h08, 32'h06040001);
		rd(8'h10, 32'h0);
		ev(7'h7F);
		rd(8'h04, 32'hB8100000);
		rd(8'h04, 32'hB8100000);
		wr(8'h04, 4'h4, 32'hFF000000);
		rd(8'h04, 32'hB8100000);
		wr(8'h04, 4'h8, 32'hFF000000);
		rd(8'h04, 32'h00100000);
		wr(8'h04, 4'h3, 32'h00000140);
		chk_pin(32'h3, {30'h0, perr_en, serr_en});
		// enabled events one at a time, cleared in between
		for (int i = 0; i < 3; i++)
		begin
			ev(evt[i]);
			rd(8'h04, stx[i]);
			wr(8'h04, 4'h8, 32'hFF000000);
		end
		ev(7'h04);
		fork
			wr(8'h04, 4'h8, 32'hFF000000);
			ev(7'h01);
		join
		rd(8'h04, 32'h80100140);
		for (int i = 0; i < 10; i++)
		begin
			v = (i < 6) ? sizes[i] : 8'(xs());
			wr(8'h0C, 4'h1, {24'(xs()), v});
			rd(8'h0C, {24'h0, v});
			chk_pin({24'h0, (v[0] || v > 8'h20) ? 8'h00 : v}, {24'h0, pf});
		end
		// mid-run reset returns every register to its reset value
		@(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		chk_pin(32'h0, {22'h0, perr_en, serr_en, pf});
		rd(8'h04, 32'h00100000);
		rd(8'h0C, 32'h0);
		repeat (3) @(negedge clk);
		chk(32'h0, 32'(expq.size()));
		complete_run();
	end
endmodule : bscc_regs_test
